// >>> hw/aps_supervisor.sv
// amplifier protection supervisor top
`timescale 1ns/1ps
module aps_supervisor #(
  parameter int unsigned HIST_DEPTH = 8,
  parameter int unsigned HOLD_CYC   = aps_pkg::HOLD_FULL_CYC,
  parameter int unsigned SHOW_CYC   = aps_pkg::SHOW_CYC,
  parameter int unsigned SWITCH_CYC = aps_pkg::SWITCH_CYC
) (
  // clock and reset
  input  wire logic                          mclk,
  input  wire logic                          sys_rst,
  // operator keys, one-cycle pulses
  input  wire logic                          keyOperate,
  input  wire logic                          keyPowerOff,
  input  wire logic                          keyPageRestore,
  input  wire logic                          keyTune,
  input  wire logic [1:0]                    powerSelect,
  input  wire logic                          powerSelectStb,
  // exciter side
  input  wire logic                          exciterOn,
  input  wire logic                          remoteHold,
  input  wire logic                          txRequest,
  input  wire logic                          carrierPresent,
  input  wire logic                          rfDrivePresent,
  input  wire logic [3:0]                    bandCode,
  input  wire logic                          linkFault,
  input  wire logic [7:0]                    driveSetpoint,
  // configuration and measurements
  input  wire aps_pkg::aps_bandcfg_t         bandCfg,
  input  wire logic                          useSecondAnt,
  input  wire logic                          tunerBypass,
  input  wire aps_pkg::aps_meas_t            meas,
  // history readout
  input  wire logic [$clog2(HIST_DEPTH)-1:0] histIdx,
  output logic      [2:0]                    histCode,
  output logic      [$clog2(HIST_DEPTH):0]   histCount,
  // amplifier control
  output logic                               powerOn,
  output logic                               operating,
  output aps_pkg::aps_power_t                powerLevel,
  output logic                               relayTx,
  output logic [7:0]                         driveLevelFeedback,
  output logic                               routeAmp,
  output logic [3:0]                         bandSel,
  output logic [aps_pkg::ANT_COUNT-1:0]      antSelect,
  output logic                               autoTuneEnable,
  output logic                               tuneStart,
  output logic                               switchBusy,
  // antenna index pins, open collector
  output logic [2:0]                         antIdxOut,
  output logic [2:0]                         antIdxOe,
  // display
  output logic [2:0]                         alarmShown,
  output logic [aps_pkg::W_BITS-1:0]         warnings
);
  initial begin
    if (HIST_DEPTH < 2) $error("history depth too small");
    if ((HIST_DEPTH & (HIST_DEPTH - 1)) != 0) $error("history depth must be a power of two");
  end

  typedef struct packed {
    logic                             on;
    logic                             oper;
    aps_pkg::aps_power_t              lvl;
    logic                             relay;
    logic [7:0]                       drv;
    logic                             route;
    logic [3:0]                       band;
    logic [aps_pkg::ANT_COUNT-1:0]    ant;
    logic                             autoTune;
    logic                             tune;
    logic                             busy;
    logic [2:0]                       idx;
    logic [2:0]                       shown;
    logic [aps_pkg::W_BITS-1:0]       warn;
    logic                             hotSeen;
    logic                             exOnQ;
  } aps_state_t;

  aps_state_t s_q;
  aps_state_t s_d;

  logic       holdDone;
  logic       showDone;
  logic       switchDone;
  logic       push;
  logic [2:0] alarmCode;
  logic       bandKnown;
  logic       bandChange;
  logic [1:0] antNum;
  logic       antRx;

  // ==========================================================
  // timers
  // carrier held at full power
  aps_timer #(.CYCLES(HOLD_CYC)) u_hold (
    .mclk(mclk), .sys_rst(sys_rst),
    .run(s_q.oper && s_q.lvl == aps_pkg::APS_PWR_FULL && carrierPresent),
    .expired(holdDone));
  aps_timer #(.CYCLES(SHOW_CYC)) u_show (
    .mclk(mclk), .sys_rst(sys_rst),
    .run(s_q.shown != aps_pkg::ALM_NONE), .expired(showDone));
  aps_timer #(.CYCLES(SWITCH_CYC)) u_sw (
    .mclk(mclk), .sys_rst(sys_rst), .run(s_q.busy), .expired(switchDone));

  // ==========================================================
  // alarm detection, priority swr, overdrive, temp, efficiency
  // one code per trip, a lower one is not shown after the higher clears, operation having stopped
  // continuous comparison
  always_comb begin
    alarmCode = aps_pkg::ALM_NONE;
    if (meas.swrX10 > aps_pkg::SWR_ALARM_X10) alarmCode = aps_pkg::ALM_SWR;
    else if (meas.inputOver) alarmCode = aps_pkg::ALM_OVDR;
    else if (meas.tempOver) alarmCode = aps_pkg::ALM_TEMP;
    else if (meas.highCurrent && meas.lowOutput) alarmCode = aps_pkg::ALM_EFF;
  end

  // only alarms raised while amplifying are stacked
  assign push = s_q.oper && alarmCode != aps_pkg::ALM_NONE;

  aps_alarm_stack #(.DEPTH(HIST_DEPTH)) u_stack (
    .mclk(mclk), .sys_rst(sys_rst), .push(push), .code(alarmCode),
    .rdIdx(histIdx), .rdCode(histCode), .count(histCount));

  // ==========================================================
  // band and antenna resolution
  // unknown codes keep the last band rather than chase a glitch
  assign bandKnown  = bandCode < 4'(aps_pkg::BAND_CODES);
  assign bandChange = bandKnown && bandCode != s_q.band;
  // at most two antennas per band
  assign antNum = (useSecondAnt && bandCfg.antCount == 2'(aps_pkg::ANT_PER_BAND)) ?
                  bandCfg.antB : bandCfg.antA;
  assign antRx  = (useSecondAnt && bandCfg.antCount == 2'(aps_pkg::ANT_PER_BAND)) ?
                  bandCfg.antBRxOnly : bandCfg.antARxOnly;

  // ==========================================================
  // main sequencing
  always_comb begin
    s_d       = s_q;
    s_d.tune  = 1'b0;
    s_d.exOnQ = exciterOn;

    if (exciterOn && !s_q.exOnQ) s_d.on = 1'b1;
    if (!exciterOn && s_q.exOnQ) s_d.on = 1'b0;
    s_d.warn[aps_pkg::W_HELD] = 1'b0;
    if (keyPowerOff) begin
      if (remoteHold) s_d.warn[aps_pkg::W_HELD] = 1'b1;
      else s_d.on = 1'b0;
    end

    if (powerSelectStb && powerSelect <= 2'(aps_pkg::APS_PWR_MIN)) begin
      s_d.lvl = aps_pkg::aps_power_t'(powerSelect);
    end
    if (holdDone && s_q.lvl == aps_pkg::APS_PWR_FULL) s_d.lvl = aps_pkg::APS_PWR_MID;
    // one step down per entry into hot region
    s_d.hotSeen = meas.tempC >= aps_pkg::TEMP_WARN_C;
    if (s_d.hotSeen && !s_q.hotSeen && s_q.lvl != aps_pkg::APS_PWR_MIN) begin
      s_d.lvl = aps_pkg::aps_power_t'(s_q.lvl + 2'h1);
    end

    if (keyOperate && s_q.on) s_d.oper = !s_q.oper;
    if (!s_d.on) s_d.oper = 1'b0;
    if (push) s_d.oper = 1'b0;

    // band change starts a timed switch
    if (bandChange) begin
      s_d.band = bandCode;
      s_d.busy = 1'b1;
    end else if (switchDone) begin
      s_d.busy = 1'b0;
    end
    s_d.ant = '0;
    if (bandCfg.antCount != 2'h0) s_d.ant[antNum] = 1'b1;

    // relay moves only with no drive present
    if (!rfDrivePresent) s_d.relay = s_d.oper && txRequest && !s_q.busy;
    // passthrough keeps exciter routed to output
    s_d.route = s_d.oper && s_d.relay;
    s_d.drv = s_d.oper ? driveSetpoint : 8'hff;

    // auto tuning disabled on high ratio
    s_d.autoTune = !tunerBypass && meas.swrX10 <= aps_pkg::SWR_TUNE_X10;
    // tune refused when bypassed or undriven
    if (keyTune) begin
      s_d.tune = !tunerBypass && !meas.lowDrive;
    end

    // antenna index, pins pulled low for zero bits
    s_d.idx = {1'b0, antNum};

    s_d.warn[aps_pkg::W_BAND]   = !bandCfg.bandAllowed;
    s_d.warn[aps_pkg::W_NOANT]  = bandCfg.antCount == 2'h0;
    s_d.warn[aps_pkg::W_RXANT]  = bandCfg.antCount != 2'h0 && antRx;
    s_d.warn[aps_pkg::W_HOT]    = s_d.hotSeen;
    s_d.warn[aps_pkg::W_HISWR]  = meas.swrX10 > aps_pkg::SWR_TUNE_X10;
    s_d.warn[aps_pkg::W_BYPASS] = keyTune ? tunerBypass : s_q.warn[aps_pkg::W_BYPASS];
    s_d.warn[aps_pkg::W_NODRV]  = keyTune ? (meas.lowDrive && !tunerBypass)
                                          : s_q.warn[aps_pkg::W_NODRV];
    s_d.warn[aps_pkg::W_CODE]   = !bandKnown;
    s_d.warn[aps_pkg::W_LINK]   = linkFault;

    // new alarm wins over key and timeout
    if (push) s_d.shown = alarmCode;
    else if (keyPageRestore || showDone) s_d.shown = aps_pkg::ALM_NONE;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_q     <= '0;
      s_q.drv <= 8'hff;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs straight from state, antIdxOut tied to zero
  assign powerOn            = s_q.on;
  assign operating          = s_q.oper;
  assign powerLevel         = s_q.lvl;
  assign relayTx            = s_q.relay;
  assign driveLevelFeedback = s_q.drv;
  assign routeAmp           = s_q.route;
  assign bandSel            = s_q.band;
  assign antSelect          = s_q.ant;
  assign autoTuneEnable     = s_q.autoTune;
  assign tuneStart          = s_q.tune;
  assign switchBusy         = s_q.busy;
  assign antIdxOut          = 3'h0;
  assign antIdxOe           = ~s_q.idx;
  assign alarmShown         = s_q.shown;
  assign warnings           = s_q.warn;

  // ==========================================================
  // checks
  a_alarm_standby: assert property (@(posedge mclk) disable iff (sys_rst)
    push |=> !operating && alarmShown == $past(alarmCode))
    else $error("serious alarm did not force passthrough");
  a_swr_alarm: assert property (@(posedge mclk) disable iff (sys_rst)
    operating && meas.swrX10 > aps_pkg::SWR_ALARM_X10 |=> alarmShown == aps_pkg::ALM_SWR)
    else $error("ratio alarm missed");
  a_eff_alarm: assert property (@(posedge mclk) disable iff (sys_rst)
    operating && meas.highCurrent && meas.lowOutput |=> !operating)
    else $error("efficiency alarm missed");
  a_relay_dry: assert property (@(posedge mclk) disable iff (sys_rst)
    rfDrivePresent |=> $stable(relayTx))
    else $error("relay moved under drive");
  a_drive_release: assert property (@(posedge mclk) disable iff (sys_rst)
    !operating |-> driveLevelFeedback == 8'hff)
    else $error("drive not released in passthrough");
  a_route_pass: assert property (@(posedge mclk) disable iff (sys_rst)
    !operating |-> !routeAmp)
    else $error("amplifier routed in passthrough");
  // relay may stay shut under drive after a trip, it opens once dry
  a_relay_open: assert property (@(posedge mclk) disable iff (sys_rst)
    !operating && !keyOperate && !rfDrivePresent |=> !relayTx)
    else $error("relay left closed in passthrough");
  a_switch_bound: assert property (@(posedge mclk) disable iff (sys_rst)
    switchDone && !bandChange |=> !switchBusy)
    else $error("switch window overran");
  a_page_restore: assert property (@(posedge mclk) disable iff (sys_rst)
    keyPageRestore && !push |=> alarmShown == aps_pkg::ALM_NONE)
    else $error("page restore ignored");
  a_power_held: assert property (@(posedge mclk) disable iff (sys_rst)
    keyPowerOff && remoteHold && powerOn && !(!exciterOn && $past(exciterOn))
      |=> warnings[aps_pkg::W_HELD])
    else $error("hold warning missing");
  a_tune_bypass: assert property (@(posedge mclk) disable iff (sys_rst)
    keyTune && tunerBypass |=> !tuneStart && warnings[aps_pkg::W_BYPASS])
    else $error("tune started while bypassed");
  a_tune_nodrive: assert property (@(posedge mclk) disable iff (sys_rst)
    keyTune && meas.lowDrive |=> !tuneStart)
    else $error("tune started without drive");
  a_hot_step: assert property (@(posedge mclk) disable iff (sys_rst)
    !powerSelectStb && !holdDone && powerLevel == aps_pkg::APS_PWR_FULL
      && meas.tempC >= aps_pkg::TEMP_WARN_C && !s_q.hotSeen
      |=> powerLevel == aps_pkg::APS_PWR_MID)
    else $error("no step down when hot");
  a_warn_unstacked: assert property (@(posedge mclk) disable iff (sys_rst)
    !push |=> $stable(histCount))
    else $error("history moved without alarm");
  a_band_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    bandCode >= 4'(aps_pkg::BAND_CODES) |=> $stable(bandSel) && warnings[aps_pkg::W_CODE])
    else $error("unknown band code accepted");

  c_alarm: cover property (@(posedge mclk) push);
  c_drop: cover property (@(posedge mclk) holdDone && powerLevel == aps_pkg::APS_PWR_FULL);
  c_band: cover property (@(posedge mclk) bandChange);
  c_tune: cover property (@(posedge mclk) tuneStart);
  c_hot: cover property (@(posedge mclk) s_d.hotSeen && !s_q.hotSeen);
endmodule

// >>> hw/aps_pkg.sv
// constants and types for the amplifier protection supervisor
// Functional notes
// - three power levels, operator or protection chosen
// - full power, 3 s carrier drops to reduced
// - band, antenna, tuner changes within 10 ms
// - passthrough routes only exciter to output
// - four antenna outputs, two per band
// - drive feedback when amplifying, released in passthrough
// - quantities monitored continuously for danger
// - alarm display cleared by key or 10 s
// - serious alarm pushed to stack, forces passthrough
// - mismatch alarm above 2.5:1 ratio
// - overdrive, overtemperature, low efficiency serious alarms
// - warnings shown but never stacked
// - band, antenna and receive-only antenna warnings
// - 75 degrees warns and steps power down
// - ratio above 5:1 disables auto tuning
// - bypassed tuner refuses all matching requests
// - low drive halts tuning with warning
// - front power-off refused while remote holds on
// - unknown band code gives warning
// - control link fault gives warning
// - power follows exciter on and off
// - relay switched only with drive absent
// - antenna index on three open-collector outputs
package aps_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned HOLD_FULL_MS  = 3000;
  localparam int unsigned SWITCH_MS     = 10;
  localparam int unsigned ALARM_SHOW_MS = 10000;
  localparam int unsigned HOLD_FULL_CYC = HOLD_FULL_MS * (CLK_HZ / 1000);
  localparam int unsigned SWITCH_CYC    = SWITCH_MS * (CLK_HZ / 1000);
  localparam int unsigned SHOW_CYC      = ALARM_SHOW_MS * (CLK_HZ / 1000);

  // ==========================================================
  // thresholds, ratio in tenths, temperature in degrees
  localparam logic [7:0] SWR_ALARM_X10 = 8'h19;
  localparam logic [7:0] SWR_TUNE_X10  = 8'h32;
  localparam logic [7:0] TEMP_WARN_C   = 8'h4b;
  localparam int unsigned ANT_COUNT    = 4;
  localparam int unsigned ANT_PER_BAND = 2;
  localparam int unsigned BAND_CODES   = 11;

  // ==========================================================
  // encodings
  typedef enum logic [1:0] {APS_PWR_FULL, APS_PWR_MID, APS_PWR_MIN} aps_power_t;

  localparam logic [2:0] ALM_NONE = 3'h0;
  localparam logic [2:0] ALM_SWR  = 3'h1;
  localparam logic [2:0] ALM_OVDR = 3'h2;
  localparam logic [2:0] ALM_TEMP = 3'h3;
  localparam logic [2:0] ALM_EFF  = 3'h4;

  // warning bit positions
  localparam int unsigned W_BAND   = 0;
  localparam int unsigned W_NOANT  = 1;
  localparam int unsigned W_RXANT  = 2;
  localparam int unsigned W_HOT    = 3;
  localparam int unsigned W_HISWR  = 4;
  localparam int unsigned W_BYPASS = 5;
  localparam int unsigned W_NODRV  = 6;
  localparam int unsigned W_HELD   = 7;
  localparam int unsigned W_CODE   = 8;
  localparam int unsigned W_LINK   = 9;
  localparam int unsigned W_BITS   = 10;

  // monitored quantities, already compared or digitised
  typedef struct packed {
    logic [7:0] swrX10;
    logic [7:0] tempC;
    logic       inputOver;
    logic       tempOver;
    logic       highCurrent;
    logic       lowOutput;
    logic       lowDrive;
  } aps_meas_t;

  // per-band antenna configuration
  typedef struct packed {
    logic       bandAllowed;
    logic [1:0] antCount;
    logic [1:0] antA;
    logic [1:0] antB;
    logic       antARxOnly;
    logic       antBRxOnly;
  } aps_bandcfg_t;

endpackage

// >>> hw/aps_alarm_stack.sv
// alarm history stack, circular, oldest entry overwritten
`timescale 1ns/1ps
module aps_alarm_stack #(
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     sys_rst,
  // push side
  input  wire logic                     push,
  input  wire logic [2:0]               code,
  // read side
  input  wire logic [$clog2(DEPTH)-1:0] rdIdx,
  output logic      [2:0]               rdCode,
  output logic      [$clog2(DEPTH):0]   count
);
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("depth must be power of two >= 2");
  end

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][2:0] mem;
    logic [AW-1:0]         wp;
    logic [AW:0]           cnt;
  } aps_stack_t;

  aps_stack_t st_q;
  aps_stack_t st_d;

  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wp] = code;
      st_d.wp = st_q.wp + 1'b1;
      if (st_q.cnt != (AW+1)'(DEPTH)) st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) st_q <= '0;
    else st_q <= st_d;
  end

  // newest entry at index zero
  assign rdCode = st_q.mem[AW'(st_q.wp - AW'(1) - rdIdx)];
  assign count  = st_q.cnt;

  a_stack_count: assert property (@(posedge mclk) disable iff (sys_rst)
    push && st_q.cnt != (AW+1)'(DEPTH) |=> st_q.cnt == $past(st_q.cnt) + 1'b1)
    else $error("stack count did not advance");
endmodule

// >>> hw/aps_timer.sv
// restartable up counter that flags expiry
`timescale 1ns/1ps
module aps_timer #(
  parameter int unsigned CYCLES = 10
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // control
  input  wire logic run,
  output logic      expired
);
  initial begin
    if (CYCLES < 1) $error("timer needs at least one cycle");
  end

  localparam int W = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         done;
  } aps_tmr_t;

  aps_tmr_t t_q;
  aps_tmr_t t_d;

  // counts while run holds, restarts when it drops
  always_comb begin
    t_d = t_q;
    if (!run) begin
      t_d.cnt  = '0;
      t_d.done = 1'b0;
    end else if (t_q.cnt != W'(CYCLES)) begin
      t_d.cnt = t_q.cnt + 1'b1;
    end else begin
      t_d.done = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) t_q <= '0;
    else t_q <= t_d;
  end

  assign expired = t_q.done;
endmodule

// >>> verification/aps_exciter_model.sv
// exciter model: power switch, keying and drive gated by the relay
`timescale 1ns/1ps
module aps_exciter_model (
  // clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // bench commands
  input  wire logic wantOn,
  input  wire logic wantTx,
  input  wire logic wantCarrier,
  // from the amplifier
  input  wire logic relayTx,
  // to the amplifier
  output logic      exciterOn,
  output logic      txRequest,
  output logic      carrierPresent,
  output logic      rfDrivePresent
);
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      exciterOn      <= 1'b0;
      txRequest      <= 1'b0;
      carrierPresent <= 1'b0;
      rfDrivePresent <= 1'b0;
    end else begin
      exciterOn      <= wantOn;
      txRequest      <= wantTx & wantOn;
      carrierPresent <= wantCarrier & wantOn;
      // drive after relay
      // drive waits for a closed relay, so a changeover never carries current
      rfDrivePresent <= wantTx & wantOn & relayTx;
    end
  end
endmodule

// >>> verification/tb.sv
// self-checking bench for the amplifier protection supervisor
`timescale 1ns/1ps
module tb;
  // ==========================================================
  // signals
  localparam int unsigned HOLD = 20;
  localparam int unsigned SHOW = 30;
  localparam int unsigned SW   = 5;
  logic                            mclk, sys_rst, keyOperate, keyPowerOff, keyPageRestore;
  logic                            keyTune, powerSelectStb, remoteHold, linkFault;
  logic                            useSecondAnt, tunerBypass, wantOn, wantTx, wantCarrier;
  logic                            exciterOn, txRequest, carrierPresent, rfDrivePresent;
  logic                            powerOn, operating, relayTx, routeAmp;
  logic                            autoTuneEnable, tuneStart, switchBusy;
  logic [1:0]                      powerSelect, histIdx;
  logic [2:0]                      histCode, histCount, antIdxOut, antIdxOe, alarmShown;
  logic [3:0]                      bandCode, bandSel, antSelect, b;
  logic [7:0]                      driveSetpoint, driveLevelFeedback;
  logic [aps_pkg::W_BITS-1:0]      warnings;
  aps_pkg::aps_power_t             powerLevel;
  aps_pkg::aps_bandcfg_t           bandCfg, cfgBase;
  aps_pkg::aps_meas_t              meas, measBase;
  int                              err_total, n_compared;

  aps_supervisor #(.HIST_DEPTH(4), .HOLD_CYC(HOLD), .SHOW_CYC(SHOW), .SWITCH_CYC(SW)) i_dut (
    .mclk(mclk), .sys_rst(sys_rst), .keyOperate(keyOperate), .keyPowerOff(keyPowerOff),
    .keyPageRestore(keyPageRestore), .keyTune(keyTune), .powerSelect(powerSelect),
    .powerSelectStb(powerSelectStb), .exciterOn(exciterOn), .remoteHold(remoteHold),
    .txRequest(txRequest), .carrierPresent(carrierPresent), .rfDrivePresent(rfDrivePresent),
    .bandCode(bandCode), .linkFault(linkFault), .driveSetpoint(driveSetpoint),
    .bandCfg(bandCfg), .useSecondAnt(useSecondAnt), .tunerBypass(tunerBypass), .meas(meas),
    .histIdx(histIdx), .histCode(histCode), .histCount(histCount), .powerOn(powerOn),
    .operating(operating), .powerLevel(powerLevel), .relayTx(relayTx),
    .driveLevelFeedback(driveLevelFeedback), .routeAmp(routeAmp), .bandSel(bandSel),
    .antSelect(antSelect), .autoTuneEnable(autoTuneEnable), .tuneStart(tuneStart),
    .switchBusy(switchBusy), .antIdxOut(antIdxOut), .antIdxOe(antIdxOe),
    .alarmShown(alarmShown), .warnings(warnings));
  aps_exciter_model i_exc (.mclk(mclk), .sys_rst(sys_rst), .wantOn(wantOn), .wantTx(wantTx),
    .wantCarrier(wantCarrier), .relayTx(relayTx), .exciterOn(exciterOn),
    .txRequest(txRequest), .carrierPresent(carrierPresent), .rfDrivePresent(rfDrivePresent));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ==========================================================
  // helpers
  // open-collector pins pull low for a zero bit, bit c never used
  function automatic logic [2:0] idxOe(input logic [1:0] a);
    return ~{1'b0, a};
  endfunction
  task automatic tick(input int n = 1);
    repeat (n) @(negedge mclk);
  endtask
  task automatic print_verdict();
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chkBit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t flag got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chkVec(input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t value got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic pulse(ref logic k);
    k = 1'b1;
    tick();
    k = 1'b0;
  endtask
  task automatic waitLow(ref logic s, input int lim);
    for (int i = 0; i < lim && s !== 1'b0; i++) tick();
    if (s !== 1'b0) begin
      err_total++;
      $display("ERROR %0t wait ran out", $time);
      print_verdict();
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {keyOperate, keyPowerOff, keyPageRestore, keyTune, powerSelectStb} = 5'h00;
    {remoteHold, linkFault, useSecondAnt, tunerBypass, wantTx, wantCarrier} = 6'h00;
    {err_total, n_compared, powerSelect, histIdx} = '0;
    measBase = '{8'h0f, 8'h28, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    cfgBase  = '{1'b1, 2'h2, 2'h2, 2'h1, 1'b0, 1'b0};
    meas = measBase;
    bandCfg = cfgBase;
    bandCode = 4'h3;
    driveSetpoint = 8'h40;
    wantOn = 1'b1;
    sys_rst = 1'b1;
    void'($urandom(56547));
    tick(2);
    chkBit(powerOn, 1'b0);
    chkVec(10'(powerLevel), 10'(aps_pkg::APS_PWR_FULL));
    chkVec(10'(driveLevelFeedback), 10'h0ff);
    chkVec(10'(antIdxOe), 10'h007);
    sys_rst = 1'b0;
    tick(3 + SW);
    chkBit(powerOn, 1'b1);
    for (int p = 0; p < 4; p++) begin
      powerSelect = 2'(p);
      pulse(powerSelectStb);
      chkVec(10'(powerLevel), 10'(p == 3 ? 2 : p));
    end
    powerSelect = 2'h0;
    pulse(powerSelectStb);
    driveSetpoint = 8'($urandom_range(0, 254));
    pulse(keyOperate);
    tick();
    chkVec(10'(driveLevelFeedback), 10'(driveSetpoint));
    {wantTx, wantCarrier} = 2'b11;
    tick(HOLD);
    chkVec(10'(powerLevel), 10'(aps_pkg::APS_PWR_FULL));
    chkBit(relayTx, 1'b1);
    chkBit(routeAmp, 1'b1);
    tick(4);
    chkVec(10'(powerLevel), 10'(aps_pkg::APS_PWR_MID));
    {wantTx, wantCarrier} = 2'b00;
    tick(4);
    chkBit(relayTx, 1'b0);
    {meas.swrX10, meas.highCurrent, linkFault} = {8'h19, 2'b11};
    tick(2);
    chkBit(operating, 1'b1);
    chkBit(warnings[aps_pkg::W_LINK], 1'b1);
    chkVec(10'(histCount), 10'h000);
    {meas, linkFault} = {measBase, 1'b0};
    pulse(keyOperate);
    chkVec(10'(driveLevelFeedback), 10'h0ff);
    for (int k = 1; k <= 5; k++) begin
      pulse(keyOperate);
      chkBit(operating, 1'b1);
      case (k)
        1, 5: meas.swrX10 = 8'h1a;
        2: meas.inputOver = 1'b1;
        3: meas.tempOver = 1'b1;
        default: {meas.highCurrent, meas.lowOutput} = 2'b11;
      endcase
      tick();
      meas = measBase;
      chkBit(operating, 1'b0);
      chkBit(routeAmp, 1'b0);
      chkVec(10'(alarmShown), 10'(k == 5 ? 1 : k));
      chkVec(10'(histCount), 10'(k > 4 ? 4 : k));
      chkVec(10'(histCode), 10'(k == 5 ? 1 : k));
      tick();
      chkVec(10'(driveLevelFeedback), 10'h0ff);
      if (k == 2) begin
        tick(SHOW - 3);
        chkVec(10'(alarmShown), 10'h002);
        tick(5);
      end else begin
        pulse(keyPageRestore);
      end
      chkVec(10'(alarmShown), 10'h000);
    end
    histIdx = 2'h3;
    #1;
    chkVec(10'(histCode), 10'h002);
    pulse(powerSelectStb);
    meas.tempC = 8'h4a;
    tick(2);
    chkBit(warnings[aps_pkg::W_HOT], 1'b0);
    meas.tempC = 8'h4b;
    tick(2);
    chkBit(warnings[aps_pkg::W_HOT], 1'b1);
    chkVec(10'(powerLevel), 10'(aps_pkg::APS_PWR_MID));
    meas = measBase;
    b = 4'((int'(bandCode) + 1 + $urandom_range(0, 9)) % 11);
    bandCode = b;
    tick();
    chkBit(switchBusy, 1'b1);
    tick(SW - 1);
    chkBit(switchBusy, 1'b1);
    waitLow(switchBusy, 4);
    chkVec(10'(bandSel), 10'(b));
    bandCode = 4'hb;
    tick(2);
    chkBit(warnings[aps_pkg::W_CODE], 1'b1);
    chkVec(10'(bandSel), 10'(b));
    bandCode = b;
    for (int s = 0; s < 2; s++) begin
      useSecondAnt = s[0];
      tick(2);
      chkVec(10'(antSelect), 10'(4'h1 << (s == 1 ? 1 : 2)));
      chkVec(10'(antIdxOe), 10'(idxOe(s == 1 ? 2'h1 : 2'h2)));
      chkVec(10'(antIdxOut), 10'h000);
    end
    useSecondAnt = 1'b0;
    for (int w = 0; w < 3; w++) begin
      bandCfg = cfgBase;
      case (w)
        0: bandCfg.bandAllowed = 1'b0;
        1: bandCfg.antCount = 2'h0;
        default: bandCfg.antARxOnly = 1'b1;
      endcase
      tick(2);
      chkBit(warnings[w], 1'b1);
    end
    bandCfg = cfgBase;
    tunerBypass = 1'b1;
    pulse(keyTune);
    chkBit(tuneStart, 1'b0);
    chkBit(warnings[aps_pkg::W_BYPASS], 1'b1);
    {tunerBypass, meas.lowDrive} = 2'b01;
    pulse(keyTune);
    chkBit(tuneStart, 1'b0);
    chkBit(warnings[aps_pkg::W_NODRV], 1'b1);
    meas.lowDrive = 1'b0;
    pulse(keyTune);
    chkBit(tuneStart, 1'b1);
    meas.swrX10 = 8'h32;
    tick(2);
    chkBit(warnings[aps_pkg::W_HISWR], 1'b0);
    chkBit(autoTuneEnable, 1'b1);
    meas.swrX10 = 8'h33;
    tick(2);
    chkBit(warnings[aps_pkg::W_HISWR], 1'b1);
    chkBit(autoTuneEnable, 1'b0);
    meas = measBase;
    remoteHold = 1'b1;
    pulse(keyPowerOff);
    chkBit(warnings[aps_pkg::W_HELD], 1'b1);
    chkBit(powerOn, 1'b1);
    remoteHold = 1'b0;
    pulse(keyPowerOff);
    chkBit(powerOn, 1'b0);
    wantOn = 1'b0;
    tick(3);
    wantOn = 1'b1;
    tick(3);
    chkBit(powerOn, 1'b1);
    wantOn = 1'b0;
    tick(3);
    chkBit(powerOn, 1'b0);
    print_verdict();
  end
endmodule
